// ===== rnpd_pkg.sv
// Constants and types shared by the reset, interrupt and power-down control
package rnpd_pkg;

  // ----------------------------------------------------------------------
  // Clock and pin timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int RST_SPIKE_NS = 10;
  localparam int RST_ACCEPT_NS = 100;
  // Longest pulse that is rejected: a least time, so round up, at least 1
  localparam int RST_SPIKE_CYC_RAW = (RST_SPIKE_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_SPIKE_CYC = (RST_SPIKE_CYC_RAW < 1) ? 1 :
                                 RST_SPIKE_CYC_RAW;
  // Pulse that must pass: a longest time, so round down, at least 1
  localparam int RST_ACCEPT_CYC_RAW = (RST_ACCEPT_NS * CLK_MHZ) / 1000;
  localparam int RST_ACCEPT_CYC = (RST_ACCEPT_CYC_RAW < 1) ? 1 :
                                  RST_ACCEPT_CYC_RAW;
  localparam int LOWCNT_W = 3;
  localparam logic [LOWCNT_W-1:0] LOWCNT_MAX = LOWCNT_W'(RST_ACCEPT_CYC);

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [LOWCNT_W-1:0] LOWCNT_RST = 3'h0;
  localparam logic SYNC_RST = 1'b1;        // Pins idle high
  localparam logic DEV_RST_RST = 1'b1;     // Device held in reset
  localparam logic TRAP_RST = 1'b0;
  localparam logic IGN_RST = 1'b0;

  // ----------------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_RUN = 2'h1,
    PWR_DOWN = 2'h2
  } rnpd_pwr_t;

endpackage

// ===== rnpd_nmi_if.sv
// Carrier for the synchronised interrupt pin level and its falling edge
`timescale 1ns/1ps
interface rnpd_nmi_if;
  logic level;   // Synchronised pin level
  logic fall;    // One-cycle pulse per falling edge

  modport src (output level, output fall);
  modport dst (input level, input fall);
endinterface

// ===== rnpd_nmi_sync.sv
// Interrupt pin synchroniser with falling-edge detector
`timescale 1ns/1ps
module rnpd_nmi_sync (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Asynchronous pin
  input wire logic nmi_pin_i,
  // Synchronised result
  rnpd_nmi_if.src nmi
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Two-stage synchroniser, third stage only for the edge compare
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      s1_r <= rnpd_pkg::SYNC_RST;
      s2_r <= rnpd_pkg::SYNC_RST;
      s3_r <= rnpd_pkg::SYNC_RST;
    end else begin
      s1_r <= nmi_pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Edge is taken after the sync so a slow edge cannot fire twice
  assign nmi.level = s2_r;
  assign nmi.fall = s3_r & ~s2_r; // see R7

  property p_fall_single;
    @(posedge clk_sys_i) disable iff (reset_i)
      nmi.fall |=> !nmi.fall;
  endproperty
  a_fall_single: assert property (p_fall_single) // see R7
    else $error("edge pulse lasted more than one cycle");

endmodule // rnpd_nmi_sync

// ===== rnpd_ctrl.sv
// Reset pin filter, interrupt trap request and power-down gating
// Summary of operation
// R1: Low reset pin with oscillator resets device
// R2: Reject spikes, accept low pulses over 100ns
// R3: Board holds pin low 100ns plus two clocks
// R4: Interrupt pin falling edge requests trap routine
// R5: Power-down instruction with interrupt low enters power-down
// R6: Power-down instruction with interrupt high is ignored
// R7: Synchronise interrupt pin; one request per edge
`timescale 1ns/1ps
module rnpd_ctrl (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Pins, active low, asynchronous
  input wire logic reset_input_pin_n_i,
  input wire logic nmi_pin_n_i,
  // From clock generation and CPU
  input wire logic osc_running_i,
  input wire logic power_down_instruction_i,
  input wire logic trap_ack_i,
  // Outputs
  output logic device_reset_o,
  output logic nmi_trap_req_o,
  output logic power_down_o,
  output logic power_down_ignored_o
);

  // ----------------------------------------------------------------------
  // Reset pin synchroniser and spike filter
  // ----------------------------------------------------------------------
  logic rpin_s1_r;
  logic rpin_s2_r;
  logic [rnpd_pkg::LOWCNT_W-1:0] lowcnt_r;
  logic [rnpd_pkg::LOWCNT_W-1:0] lowcnt_nxt;
  logic dev_rst_r;
  logic dev_rst_nxt;
  wire lowcnt_full = (lowcnt_r == rnpd_pkg::LOWCNT_MAX);

  // Count consecutive low samples; any high sample restarts the count
  assign lowcnt_nxt = rpin_s2_r ? rnpd_pkg::LOWCNT_RST :
                      lowcnt_full ? lowcnt_r :
                      rnpd_pkg::LOWCNT_W'(lowcnt_r + 3'h1); // see R2
  // Reset only once the pin has stayed low long enough, clock alive
  assign dev_rst_nxt = osc_running_i &
                       (lowcnt_nxt == rnpd_pkg::LOWCNT_MAX); // see R1

  // Sampling at 25 ns already hides most sub-10 ns spikes; the count
  // guarantees a single-sample glitch can never reach the device
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rpin_s1_r <= rnpd_pkg::SYNC_RST;
      rpin_s2_r <= rnpd_pkg::SYNC_RST;
      lowcnt_r <= rnpd_pkg::LOWCNT_RST;
      dev_rst_r <= rnpd_pkg::DEV_RST_RST;
    end else begin
      rpin_s1_r <= reset_input_pin_n_i;
      rpin_s2_r <= rpin_s1_r;
      lowcnt_r <= lowcnt_nxt;
      dev_rst_r <= dev_rst_nxt;
    end
  end

  assign device_reset_o = dev_rst_r;

  // ----------------------------------------------------------------------
  // Interrupt pin and trap request
  // ----------------------------------------------------------------------
  rnpd_nmi_if nmi ();

  rnpd_nmi_sync u_nmi_sync (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .nmi_pin_i(nmi_pin_n_i),
    .nmi(nmi)
  );

  logic trap_r;
  logic trap_nxt;

  // A new edge in the acknowledge cycle wins, so no trap is lost
  assign trap_nxt = dev_rst_r ? rnpd_pkg::TRAP_RST :
                    nmi.fall ? 1'b1 :
                    (trap_ack_i ? 1'b0 : trap_r); // see R4

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      trap_r <= rnpd_pkg::TRAP_RST;
    end else begin
      trap_r <= trap_nxt;
    end
  end

  assign nmi_trap_req_o = trap_r;

  // ----------------------------------------------------------------------
  // Power-down gating
  // ----------------------------------------------------------------------
  rnpd_pkg::rnpd_pwr_t state_r;
  rnpd_pkg::rnpd_pwr_t state_nxt;
  logic ign_r;
  logic ign_nxt;
  wire pd_req = power_down_instruction_i & ~dev_rst_r;
  wire pd_go = pd_req & ~nmi.level;  // see R5
  wire pd_skip = pd_req & nmi.level; // see R6

  // Power-down is left only through a device reset
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      rnpd_pkg::PWR_RUN: begin
        if (pd_go) begin
          state_nxt = rnpd_pkg::PWR_DOWN; // see R5
        end
      end
      rnpd_pkg::PWR_DOWN: begin
        if (dev_rst_r) begin
          state_nxt = rnpd_pkg::PWR_RUN;
        end
      end
      default: begin
        state_nxt = rnpd_pkg::PWR_RUN;
      end
    endcase
  end

  // Pulse that flags a refused power-down; the part keeps running
  assign ign_nxt = pd_skip & (state_r == rnpd_pkg::PWR_RUN); // see R6

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= rnpd_pkg::PWR_RUN;
      ign_r <= rnpd_pkg::IGN_RST;
    end else begin
      state_r <= state_nxt;
      ign_r <= ign_nxt;
    end
  end

  assign power_down_o = (state_r == rnpd_pkg::PWR_DOWN);
  assign power_down_ignored_o = ign_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_reset_accept;
    @(posedge clk_sys_i) disable iff (reset_i)
      (!rpin_s2_r && osc_running_i) [*4] |=> device_reset_o;
  endproperty
  a_reset_accept: assert property (p_reset_accept) // see R1
    else $error("long low reset pin did not reset device");

  property p_spike_reject;
    @(posedge clk_sys_i) disable iff (reset_i)
      $rose(device_reset_o) |-> !$past(rpin_s2_r, 1) && !$past(rpin_s2_r, 4);
  endproperty
  a_spike_reject: assert property (p_spike_reject) // see R2
    else $error("reset entered on a short pulse");

  property p_reset_release;
    @(posedge clk_sys_i) disable iff (reset_i)
      rpin_s2_r |=> !device_reset_o;
  endproperty
  a_reset_release: assert property (p_reset_release) // see R1
    else $error("device reset held with pin high");

  property p_trap_set;
    @(posedge clk_sys_i) disable iff (reset_i)
      nmi.fall && !device_reset_o |=> nmi_trap_req_o;
  endproperty
  a_trap_set: assert property (p_trap_set) // see R4
    else $error("falling edge gave no trap request");

  property p_trap_hold;
    @(posedge clk_sys_i) disable iff (reset_i)
      nmi_trap_req_o && !trap_ack_i && !device_reset_o |=> nmi_trap_req_o;
  endproperty
  a_trap_hold: assert property (p_trap_hold) // see R4
    else $error("trap request dropped without acknowledge");

  property p_pd_enter;
    @(posedge clk_sys_i) disable iff (reset_i)
      power_down_instruction_i && !nmi.level && !device_reset_o
        |=> power_down_o;
  endproperty
  a_pd_enter: assert property (p_pd_enter) // see R5
    else $error("power-down not entered with interrupt pin low");

  property p_pd_ignore;
    @(posedge clk_sys_i) disable iff (reset_i)
      power_down_instruction_i && nmi.level && !power_down_o
        |=> !power_down_o && (power_down_ignored_o || $past(device_reset_o));
  endproperty
  a_pd_ignore: assert property (p_pd_ignore) // see R6
    else $error("power-down taken with interrupt pin high");

  property p_pd_hold;
    @(posedge clk_sys_i) disable iff (reset_i)
      power_down_o && !device_reset_o |=> power_down_o;
  endproperty
  a_pd_hold: assert property (p_pd_hold) // see R5
    else $error("power-down left without reset");

  property p_osc_gate;
    @(posedge clk_sys_i) disable iff (reset_i)
      !osc_running_i |=> !device_reset_o;
  endproperty
  a_osc_gate: assert property (p_osc_gate) // see R1
    else $error("device reset without running oscillator");

  property p_trap_refused;
    @(posedge clk_sys_i) disable iff (reset_i)
      device_reset_o |=> !nmi_trap_req_o;
  endproperty
  a_trap_refused: assert property (p_trap_refused) // see R4
    else $error("trap request kept during device reset");

  property p_trap_clear;
    @(posedge clk_sys_i) disable iff (reset_i)
      nmi_trap_req_o && trap_ack_i && !nmi.fall |=> !nmi_trap_req_o;
  endproperty
  a_trap_clear: assert property (p_trap_clear) // see R4
    else $error("trap request not cleared by acknowledge");

  property p_ign_running;
    @(posedge clk_sys_i) disable iff (reset_i)
      power_down_ignored_o |-> !power_down_o;
  endproperty
  a_ign_running: assert property (p_ign_running) // see R6
    else $error("refused power-down left the part powered down");

endmodule // rnpd_ctrl

// ===== rnpd_pin_model.sv
// Board supervisor and interrupt source driving the two pins
`timescale 1ns/1ps
module rnpd_pin_model (
  // Clock seen by the board
  input wire logic clk_sys_i,
  // Pins, active low, idle high as with the pull-ups
  output logic reset_input_pin_n_o,
  output logic nmi_pin_n_o
);
  initial begin
    reset_input_pin_n_o = 1'b1;
    nmi_pin_n_o = 1'b1;
  end

  // Reset pulse never shorter than 100 ns plus two clocks
  task automatic pulse_reset(input int n);
    reset_input_pin_n_o = 1'b0;
    repeat ((n < 6) ? 6 : n) @(negedge clk_sys_i);
    reset_input_pin_n_o = 1'b1;
  endtask

  // Glitch of 5 ns across a rising edge, so the sampler does see it
  task automatic spike;
    #10 reset_input_pin_n_o = 1'b0;
    #5 reset_input_pin_n_o = 1'b1;
  endtask

  // Interrupt pin level, changed off the sampling edge
  task automatic set_nmi(input logic v);
    nmi_pin_n_o = v;
  endtask
endmodule // rnpd_pin_model

// ===== tb_reset_nmi_powerdown_ctrl.sv
// Self-checking bench for the reset, interrupt and power-down control
`timescale 1ns/1ps
module tb_reset_nmi_powerdown_ctrl;
  logic clk_sys_i;
  logic reset_i;
  logic osc_i;
  logic pd_instr;
  logic ack;
  logic rst_pin_n;
  logic nmi_pin_n;
  logic dev_rst;
  logic req;
  logic pd;
  logic pd_ign;
  int n_fail = 0;
  int checks = 0;
  int k;

  // 40 MHz clock
  always #12.5 clk_sys_i = ~clk_sys_i;

  rnpd_pin_model mdl (
    .clk_sys_i(clk_sys_i),
    .reset_input_pin_n_o(rst_pin_n),
    .nmi_pin_n_o(nmi_pin_n)
  );

  rnpd_ctrl dut (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .reset_input_pin_n_i(rst_pin_n),
    .nmi_pin_n_i(nmi_pin_n),
    .osc_running_i(osc_i),
    .power_down_instruction_i(pd_instr),
    .trap_ack_i(ack),
    .device_reset_o(dev_rst),
    .nmi_trap_req_o(req),
    .power_down_o(pd),
    .power_down_ignored_o(pd_ign)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %b, seen %b", what, exp, seen);
    end
  endtask

  // Inputs move and outputs are read at the falling edge, except the mid-cycle reset-pin spike
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // Bounded wait on the device reset; k counts the cycles taken
  task automatic wait_rst(input logic v, input int n);
    k = 0;
    while (dev_rst !== v && k < n) begin
      cyc(1);
      k++;
    end
  endtask

  task automatic complete_run;
    $display("checks %0d, n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Spike rejected, long pulse resets, release ends the reset
  task automatic t_reset_pin;
    mdl.spike();
    cyc(8);
    check("reset after spike", dev_rst, 1'b0);
    fork
      mdl.pulse_reset(6);
      wait_rst(1'b1, 8);
    join
    check("reset on long pulse", dev_rst, 1'b1);
    check("reset delay", logic'(k == 2 + rnpd_pkg::RST_ACCEPT_CYC), 1'b1);
    wait_rst(1'b0, 6);
    check("reset released", dev_rst, 1'b0);
    check("release delay", logic'(k == 3), 1'b1);
  endtask

  // Without the oscillator the pin has no effect
  task automatic t_no_osc;
    osc_i = 1'b0;
    fork
      mdl.pulse_reset(10);
      cyc(9);
    join_any
    check("reset without oscillator", dev_rst, 1'b0);
    // Synced pin must be high before the clock returns, else reset fires
    cyc(4);
    osc_i = 1'b1;
  endtask

  // One falling edge, pin held low: exactly one request
  task automatic t_nmi;
    mdl.set_nmi(1'b0);
    cyc(5);
    check("trap request", req, 1'b1);
    ack = 1'b1;
    cyc(1);
    ack = 1'b0;
    cyc(6);
    check("trap after ack", req, 1'b0);
  endtask

  // Instruction with pin high is refused, with pin low it is taken
  task automatic t_power_down;
    mdl.set_nmi(1'b1);
    cyc(4);
    pd_instr = 1'b1;
    cyc(1);
    pd_instr = 1'b0;
    check("ignored pulse", pd_ign, 1'b1);
    check("still running", pd, 1'b0);
    cyc(1);
    check("ignored is one cycle", pd_ign, 1'b0);
    t_nmi();
    pd_instr = 1'b1;
    cyc(1);
    pd_instr = 1'b0;
    check("power down", pd, 1'b1);
    check("no refusal", pd_ign, 1'b0);
    fork
      mdl.pulse_reset(6);
      wait_rst(1'b1, 8);
    join
    cyc(2);
    check("power down left on reset", pd, 1'b0);
    mdl.set_nmi(1'b1);
    wait_rst(1'b0, 6);
  endtask

  // Hang guard, well beyond the roughly 90 cycles of the run
  initial begin
    #50000;
    n_fail++;
    complete_run();
  end

  initial begin
    clk_sys_i = 1'b0;
    reset_i = 1'b1;
    osc_i = 1'b1;
    pd_instr = 1'b0;
    ack = 1'b0;
    cyc(16);
    reset_i = 1'b0;
    cyc(4);
    check("reset after start", dev_rst, 1'b0);
    t_reset_pin();
    t_no_osc();
    t_nmi();
    t_power_down();
    complete_run();
  end
endmodule // tb_reset_nmi_powerdown_ctrl
